/* File: include/pattern_sync_indicator_ais_defs.vh */
// What this block does
// - Alarm frame starts with first subframe lead bit
// - Payload blocks alternate, one first after overhead
// - Pattern unframed, no framing bits inserted
// - 15-bit sequence for DS3/STS-1, 23-bit for E3
// - Both source selects high sends test sequence
// - Detector always runs on received data
// - Status pin driven in both modes
// - Out of sync holds status pin high
// - In sync: low, one pulse per error
// - Sync status bit reads one when unsynced
// - Sync change latches, interrupt if enabled
// - Bit error latches, interrupt if enabled
// - Recovered clock output beside recovered data
`ifndef PATTERN_SYNC_INDICATOR_AIS_DEFS_VH
`define PATTERN_SYNC_INDICATOR_AIS_DEFS_VH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define REG_CONFIG 8'h00
`define REG_STATUS 8'h04
`define REG_LATCH 8'h08
`define REG_IRQ_EN 8'h0c

// Field positions
`define CFG_SRC_A 0
`define CFG_SRC_B 1
`define CFG_AIS 2
`define CFG_E3 3
`define ST_SYNC 0
`define ST_ERR 1
`define LT_SYNC 0
`define LT_ERR 1

// Reset values
`define CONFIG_RST 4'h0
`define IRQ_EN_RST 2'h0

// Timing and sizes
`define PAYLOAD_BITS 84
`define OVH_PER_SUB 8
`define SUBFRAMES 7
`define SYNC_COUNT 6'h20
`define LOSS_ERRS 4'h8

`endif

/* File: rtl/pattern_sync_indicator_lfsr.v */
`timescale 1ns/1ps
`include "pattern_sync_indicator_ais_defs.vh"

// ****************************************************************
// Shared pseudorandom shift register, 15 or 23 stage
// ****************************************************************
module pattern_sync_indicator_lfsr #(
    parameter W = 23
) (
    input wire core_clk,
    input wire nrst,
    input wire advance,
    input wire use_long,
    input wire load,
    input wire load_bit,
    output wire next_bit,
    output reg [W-1:0] state_q
);
    // Feedback: x^15+x^14+1 or x^23+x^18+1, unframed
    assign next_bit = use_long ? (state_q[22] ^ state_q[17]) :
                                 (state_q[14] ^ state_q[13]);

    // Shift either generated or loaded bits
    always @(posedge core_clk) begin
        if (!nrst) begin
            state_q <= {W{1'b1}};
        end else if (advance) begin
            state_q <= {state_q[W-2:0], load ? load_bit : next_bit};
        end
    end
endmodule

/* File: rtl/pattern_sync_indicator_ais_test_pattern.v */
`timescale 1ns/1ps
`include "pattern_sync_indicator_ais_defs.vh"

module pattern_sync_indicator_ais_test_pattern (
    input wire core_clk,
    input wire nrst,
    input wire hardware_mode_select,
    input wire pin_tx_source_sel_a,
    input wire pin_tx_source_sel_b,
    input wire pin_e3_mode,
    input wire tx_bit_en,
    input wire tx_user_data,
    output reg tx_line_data_q,
    input wire rx_bit_en,
    input wire rx_line_data,
    output reg rx_data_q,
    output reg rx_clk_en_q,
    output reg pattern_status_pin_q,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output wire irq
);
    // ****************************************************************
    // Registers and configuration
    // ****************************************************************
    reg [3:0] config_q;
    reg [1:0] latch_q;
    reg [1:0] irq_en_q;
    reg pattern_sync_indicator_q;
    reg pattern_error_status_q;
    wire src_a;
    wire src_b;
    wire e3_sel;
    wire send_pattern_sync_indicator;
    wire send_ais;

    // Pins in hardware mode, register bits in bus mode; the alarm select is always the register bit
    assign src_a = hardware_mode_select ? pin_tx_source_sel_a : config_q[`CFG_SRC_A];
    assign src_b = hardware_mode_select ? pin_tx_source_sel_b : config_q[`CFG_SRC_B];
    assign e3_sel = hardware_mode_select ? pin_e3_mode : config_q[`CFG_E3];
    assign send_pattern_sync_indicator = src_a & src_b;
    assign send_ais = ~send_pattern_sync_indicator & config_q[`CFG_AIS];

    // ****************************************************************
    // Transmit: pattern generator
    // ****************************************************************
    wire gen_bit;

    pattern_sync_indicator_lfsr #(.W(23)) u_gen (
        .core_clk(core_clk),
        .nrst(nrst),
        .advance(tx_bit_en & send_pattern_sync_indicator),
        .use_long(e3_sel),
        .load(1'b0),
        .load_bit(1'b0),
        .next_bit(gen_bit),
        .state_q()
    );

    // ****************************************************************
    // Transmit: alarm indication frame
    // ****************************************************************
    reg [2:0] ais_sub_q;
    reg [2:0] ais_ovh_q;
    reg [6:0] ais_pos_q;
    wire ais_bit;

    // Overhead bit value by subframe and position
    function ovh_value;
        input [2:0] sub;
        input [2:0] pos;
        begin
            if (pos == 3'h0) begin
                ovh_value = (sub == 3'h0) | (sub == 3'h1) | (sub == 3'h5);
            end else if (pos == 3'h1 || pos == 3'h7) begin
                ovh_value = 1'b1;
            end else begin
                ovh_value = 1'b0;
            end
        end
    endfunction

    // Position 0 is overhead, then 84 payload bits starting with one
    assign ais_bit = (ais_pos_q == 7'h00) ? ovh_value(ais_sub_q, ais_ovh_q) :
                     ais_pos_q[0];

    // Walk subframe, overhead slot and payload position
    // Held at the first lead bit while the frame is off, so it always starts clean
    always @(posedge core_clk) begin
        if (!nrst || !send_ais) begin
            ais_sub_q <= 3'h0;
            ais_ovh_q <= 3'h0;
            ais_pos_q <= 7'h00;
        end else if (tx_bit_en) begin
            if (ais_pos_q == `PAYLOAD_BITS) begin
                ais_pos_q <= 7'h00;
                if (ais_ovh_q == `OVH_PER_SUB - 1) begin
                    ais_ovh_q <= 3'h0;
                    ais_sub_q <= (ais_sub_q == `SUBFRAMES - 1) ? 3'h0 : ais_sub_q + 3'h1;
                end else begin
                    ais_ovh_q <= ais_ovh_q + 3'h1;
                end
            end else begin
                ais_pos_q <= ais_pos_q + 7'h01;
            end
        end
    end

    // Output mux for transmit line
    // Test sequence wins when both sources are selected
    always @(posedge core_clk) begin
        if (!nrst) begin
            tx_line_data_q <= 1'b0;
        end else if (tx_bit_en) begin
            if (send_pattern_sync_indicator) begin
                tx_line_data_q <= gen_bit;
            end else if (send_ais) begin
                tx_line_data_q <= ais_bit;
            end else begin
                tx_line_data_q <= tx_user_data;
            end
        end
    end

    // ****************************************************************
    // Receive: recovered clock and data pass-through
    // ****************************************************************
    // Recovered strobe is delayed with the data so both leave aligned
    always @(posedge core_clk) begin
        if (!nrst) begin
            rx_data_q <= 1'b0;
            rx_clk_en_q <= 1'b0;
        end else begin
            rx_clk_en_q <= rx_bit_en;
            if (rx_bit_en) begin
                rx_data_q <= rx_line_data;
            end
        end
    end

    // ****************************************************************
    // Receive: pattern detector, always enabled
    // ****************************************************************
    wire det_pred;
    reg [5:0] good_cnt_q;
    reg [3:0] bad_cnt_q;
    reg in_sync_q;
    reg err_pulse_q;
    wire mismatch;

    assign mismatch = det_pred ^ rx_line_data;

    pattern_sync_indicator_lfsr #(.W(23)) u_det (
        .core_clk(core_clk),
        .nrst(nrst),
        .advance(rx_bit_en),
        .use_long(e3_sel),
        .load(~in_sync_q),
        .load_bit(rx_line_data),
        .next_bit(det_pred),
        .state_q()
    );

    // Sync search self-seeds; loss after repeated errors
    // Once locked the register runs on its own prediction, so one bad bit gives one pulse
    // Eight errors are needed to drop lock, so a burst of noise only pulses the pin
    always @(posedge core_clk) begin
        if (!nrst) begin
            good_cnt_q <= 6'h00;
            bad_cnt_q <= 4'h0;
            in_sync_q <= 1'b0;
            err_pulse_q <= 1'b0;
        end else begin
            err_pulse_q <= 1'b0;
            if (rx_bit_en) begin
                if (!in_sync_q) begin
                    good_cnt_q <= mismatch ? 6'h00 : good_cnt_q + 6'h01;
                    if (!mismatch && good_cnt_q == `SYNC_COUNT - 6'h01) begin
                        in_sync_q <= 1'b1;
                        bad_cnt_q <= 4'h0;
                    end
                end else if (mismatch) begin
                    err_pulse_q <= 1'b1;
                    bad_cnt_q <= bad_cnt_q + 4'h1;
                    if (bad_cnt_q == `LOSS_ERRS - 4'h1) begin
                        in_sync_q <= 1'b0;
                        good_cnt_q <= 6'h00;
                    end
                end
            end
        end
    end

    // Status pin: high out of sync, error pulses when in sync
    // Reset leaves the pin high: a detector that has not locked reports out of sync
    always @(posedge core_clk) begin
        if (!nrst) begin
            pattern_status_pin_q <= 1'b1;
        end else begin
            pattern_status_pin_q <= ~in_sync_q | err_pulse_q;
        end
    end

    // ****************************************************************
    // Status bits, latches and interrupt
    // ****************************************************************
    reg aw_hold_q;
    reg w_hold_q;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg w_strb_q;
    wire do_write;
    wire sync_change;
    reg [1:0] clr_mask;

    // Compare against the next value so the latch sets in the same cycle as the bit
    assign sync_change = pattern_sync_indicator_q != ~in_sync_q;
    assign do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;

    // Write-one-to-clear mask for latched bits
    always @* begin
        clr_mask = 2'h0;
        if (do_write && aw_addr_q == `REG_LATCH && w_strb_q) begin
            clr_mask = w_data_q[1:0];
        end
    end

    // Live status and sticky events; set wins over clear
    always @(posedge core_clk) begin
        if (!nrst) begin
            pattern_sync_indicator_q <= 1'b1;
            pattern_error_status_q <= 1'b0;
            latch_q <= 2'h0;
        end else begin
            pattern_sync_indicator_q <= ~in_sync_q;
            pattern_error_status_q <= err_pulse_q;
            latch_q[`LT_SYNC] <= sync_change | (latch_q[`LT_SYNC] & ~clr_mask[0]);
            latch_q[`LT_ERR] <= err_pulse_q | (latch_q[`LT_ERR] & ~clr_mask[1]);
        end
    end

    assign irq = |(latch_q & irq_en_q);

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    assign s_axi_awready = ~aw_hold_q;
    assign s_axi_wready = ~w_hold_q;
    assign s_axi_arready = ~s_axi_rvalid;

    // True for the four register offsets; others answer with an error
    function addr_mapped;
        input [7:0] addr;
        begin
            addr_mapped = (addr == `REG_CONFIG) || (addr == `REG_STATUS) ||
                          (addr == `REG_LATCH) || (addr == `REG_IRQ_EN);
        end
    endfunction

    // Write channel capture, register update and response
    always @(posedge core_clk) begin
        if (!nrst) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            config_q <= `CONFIG_RST;
            irq_en_q <= `IRQ_EN_RST;
        end else begin
            if (s_axi_awvalid && !aw_hold_q) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_q) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                // Strobe is kept with the data; the live pin may have moved on
                w_strb_q <= s_axi_wstrb[0];
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                if (aw_addr_q == `REG_CONFIG) begin
                    if (w_strb_q) begin
                        config_q <= w_data_q[3:0];
                    end
                end else if (aw_addr_q == `REG_IRQ_EN) begin
                    if (w_strb_q) begin
                        irq_en_q <= w_data_q[1:0];
                    end
                end else if (!addr_mapped(aw_addr_q)) begin
                    s_axi_bresp <= 2'h2;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
            end
        end
    end

    // Read channel
    always @(posedge core_clk) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= addr_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            if (s_axi_araddr == `REG_CONFIG) begin
                s_axi_rdata <= {28'h0, config_q};
            end else if (s_axi_araddr == `REG_STATUS) begin
                s_axi_rdata <= {30'h0, pattern_error_status_q, pattern_sync_indicator_q};
            end else if (s_axi_araddr == `REG_LATCH) begin
                s_axi_rdata <= {30'h0, latch_q};
            end else if (s_axi_araddr == `REG_IRQ_EN) begin
                s_axi_rdata <= {30'h0, irq_en_q};
            end else begin
                s_axi_rdata <= 32'h0;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* File: testbench/pattern_sync_indicator_ais_test_pattern_properties.sv */
`timescale 1ns/1ps
// ********
// Port checker
// ********
module pattern_sync_indicator_ais_props (
    input wire core_clk,
    input wire nrst,
    input wire tx_bit_en,
    input wire tx_line_data_q,
    input wire rx_bit_en,
    input wire rx_line_data,
    input wire rx_data_q,
    input wire rx_clk_en_q,
    input wire pattern_status_pin_q,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Recovered strobe and data one cycle behind the line
    a_rx_recovered: assert property (
        rx_bit_en |=> rx_clk_en_q && (rx_data_q == $past(rx_line_data))) else $error("rx out");
    a_tx_stands: assert property (
        !$past(tx_bit_en) |-> $stable(tx_line_data_q)) else $error("tx moved");
    a_pin_rise_cause: assert property (
        $rose(pattern_status_pin_q) |-> $past(rx_bit_en, 2)) else $error("pin rose");
    a_b_blocks_aw: assert property (
        s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
    a_r_blocks_ar: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
    a_r_single: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("r twice");
    a_b_single: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b twice");
    a_irq_fall_write: assert property (
        $fell(irq) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || s_axi_bvalid
            || $past(s_axi_bvalid)) else $error("irq fell");
endmodule

bind pattern_sync_indicator_ais_test_pattern pattern_sync_indicator_ais_props props_u (.core_clk(core_clk), .nrst(nrst),
    .tx_bit_en(tx_bit_en), .tx_line_data_q(tx_line_data_q), .rx_bit_en(rx_bit_en),
    .rx_line_data(rx_line_data), .rx_data_q(rx_data_q), .rx_clk_en_q(rx_clk_en_q),
    .pattern_status_pin_q(pattern_status_pin_q), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq));

/* File: testbench/line_partner.sv */
`timescale 1ns/1ps
// ********
// Far-end line equipment
// ********
module line_partner (
    input wire core_clk,
    input wire nrst,
    input wire run,
    input wire loop_back,
    input wire inject,
    input wire tx_data,
    output logic bit_en_q,
    output wire rx_data
);
    logic [1:0] cnt_q;
    logic [14:0] seq_q;
    // Bit strobe every fourth cycle while running
    always @(posedge core_clk) begin
        cnt_q <= (!nrst || !run) ? 2'h0 : cnt_q + 2'h1;
        bit_en_q <= nrst && run && (cnt_q == 2'h3);
    end
    // Unframed 15-stage sequence, no framing bits
    always @(posedge core_clk) begin
        if (!nrst) begin
            seq_q <= 15'h7fff;
        end else if (bit_en_q) begin
            seq_q <= {seq_q[13:0], seq_q[14] ^ seq_q[13]};
        end
    end
    // Own sequence with an optional flipped bit, or looped transmit data
    assign rx_data = loop_back ? tx_data : seq_q[14] ^ inject;
endmodule

/* File: testbench/pattern_sync_indicator_ais_test_pattern_bench.sv */
`timescale 1ns/1ps
`include "pattern_sync_indicator_ais_defs.vh"
module pattern_sync_indicator_ais_test_pattern_bench;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] resp;} row_t;
    localparam logic [6:0] LEADS = 7'h23;
    localparam logic [7:0] OVH = 8'h82;
    logic core_clk = 1'b0, nrst = 1'b0, hardware_mode_select = 1'b0, pin_e3_mode = 1'b0;
    logic pin_tx_source_sel_a = 1'b0, pin_tx_source_sel_b = 1'b0;
    logic run = 1'b0, loop_back = 1'b0, inject = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, rd;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    wire bit_en, rx_line_data, tx_line_data_q, pattern_status_pin_q, irq;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    logic bits [0:4759];
    logic [1:0] rs;
    int n_errors = 0, check_count = 0, cyc = 0, hi, runlen, maxrun;
    row_t rows [5] = '{'{`REG_CONFIG, 32'hc, 32'hc, 2'h0}, '{`REG_IRQ_EN, 32'hffffffff, 32'h3,
        2'h0}, '{`REG_IRQ_EN, 32'h0, 32'h0, 2'h0}, '{8'h10, 32'h1, 32'h0, 2'h2},
        '{`REG_CONFIG, 32'h0, 32'h0, 2'h0}};

    // ********
    // Design, far end, clock and timeout
    // ********
    pattern_sync_indicator_ais_test_pattern dut_u (.core_clk, .nrst, .hardware_mode_select, .pin_tx_source_sel_a,
        .pin_tx_source_sel_b, .pin_e3_mode, .tx_bit_en(bit_en), .tx_user_data(1'b1),
        .tx_line_data_q, .rx_bit_en(bit_en), .rx_line_data, .rx_data_q(), .rx_clk_en_q(),
        .pattern_status_pin_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .irq);
    line_partner partner_u (.core_clk, .nrst, .run, .loop_back, .inject,
        .tx_data(tx_line_data_q), .bit_en_q(bit_en), .rx_data(rx_line_data));
    always #5 core_clk = ~core_clk;
    // Cut a hang short
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ********
    // Tasks
    // ********
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
    endtask
    task automatic axr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    task automatic cap(input int n);
        for (int i = 0; i < n; i++) begin
            do @(posedge core_clk); while (bit_en !== 1'b1);
            @(posedge core_clk);
            bits[i] = tx_line_data_q;
        end
    endtask
    task automatic seq_chk(input int t);
        int l;
        l = (t == 14) ? 15 : 23;
        cap(100);
        for (int n = 23; n < 100; n++) chk("tx sequence", bits[n-l] ^ bits[n-t], bits[n]);
    endtask
    task automatic watch(input int n);
        hi = 0;
        runlen = 0;
        maxrun = 0;
        repeat (n) begin
            @(posedge core_clk);
            runlen = (pattern_status_pin_q === 1'b1) ? runlen + 1 : 0;
            hi += (runlen > 0);
            maxrun = (runlen > maxrun) ? runlen : maxrun;
        end
    endtask
    task automatic next_bit();
        do @(posedge core_clk); while (bit_en !== 1'b1);
    endtask
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ********
    // Main sequence
    // ********
    initial begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        chk("pin in reset", 1, pattern_status_pin_q);
        chk("irq in reset", 0, irq);
        axr(`REG_IRQ_EN);
        chk("irq enable reset", `IRQ_EN_RST, rd);
        foreach (rows[k]) begin
            axw(rows[k].a, rows[k].w);
            chk("write resp", rows[k].resp, rs);
            axr(rows[k].a);
            chk("read data", rows[k].r, rd);
            chk("read resp", rows[k].resp, rs);
        end
        run <= 1'b1;
        watch(400);
        watch(40);
        chk("pin synced", 0, hi);
        axr(`REG_STATUS);
        chk("sync bit", 0, rd[0]);
        axr(`REG_LATCH);
        chk("sync latch", 1, rd[0]);
        chk("irq masked", 0, irq);
        axw(`REG_IRQ_EN, 32'h1);
        @(posedge core_clk);
        chk("irq sync", 1, irq);
        axw(`REG_LATCH, 32'h3);
        axw(`REG_IRQ_EN, 32'h2);
        @(posedge core_clk);
        chk("irq cleared", 0, irq);
        next_bit();
        inject <= 1'b1;
        next_bit();
        inject <= 1'b0;
        watch(40);
        chk("error pulse", 1, maxrun);
        chk("irq error", 1, irq);
        axr(`REG_LATCH);
        chk("error latch", 1, rd[1]);
        loop_back <= 1'b1;
        watch(200);
        watch(20);
        chk("pin unsynced", 20, hi);
        axr(`REG_STATUS);
        chk("sync lost", 1, rd[0]);
        axw(`REG_CONFIG, 32'h3);
        watch(500);
        watch(40);
        chk("pin on own sequence", 0, hi);
        seq_chk(14);
        hardware_mode_select <= 1'b1;
        pin_tx_source_sel_a <= 1'b1;
        pin_tx_source_sel_b <= 1'b1;
        pin_e3_mode <= 1'b1;
        seq_chk(18);
        pin_tx_source_sel_b <= 1'b0;
        cap(20);
        for (int i = 2; i < 20; i++) chk("user data", 1, bits[i]);
        hardware_mode_select <= 1'b0;
        run <= 1'b0;
        axw(`REG_CONFIG, 32'h4);
        run <= 1'b1;
        cap(4760);
        for (int i = 0; i < 4760; i++) begin
            chk("alarm bit", (i % 680 % 85) ? i % 680 % 85 % 2
                : (i % 680) ? OVH[i % 680 / 85] : LEADS[i / 680], bits[i]);
        end
        tally_and_finish();
    end
endmodule
